// ---- verilog/cmptrm_top.sv ----
// Top of the two-channel comparator trim and interrupt block
// Assumes a one-cycle strobe register port and analog comparators outside
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cmptrm_map.svh"
module cmptrm_top (
	input wire logic CLK_IN, // System clock 100 MHz
	input wire logic RSTN_IN, // Synchronous reset, low
	input wire cmptrm_pkg::cmptrm_addr_t ADDR_IN, // Register address
	input wire cmptrm_pkg::cmptrm_byte_t WDATA_IN, // Write data
	input wire logic WR_IN, // Write strobe
	input wire logic RD_IN, // Read strobe
	input wire logic SLEEP_IN, // Processor in sleep or idle
	input wire logic [1:0] RAW_IN, // Analog decisions, plus over minus
	output cmptrm_pkg::cmptrm_byte_t RDATA_OUT, // Read data
	output logic IRQ_OUT, // Interrupt level
	output logic WAKE_OUT, // Wake request, one-cycle pulse when a flag newly sets in sleep, one pulse if both set together
	output logic [1:0] POWER_OUT, // Analog power enables
	output logic [1:0] HYST_OUT, // Hysteresis enables
	output logic [1:0] REF_POS_OUT, // Calibration reference positive
	output logic [9:0] TRIM_OUT // Trim codes, channel 1 high
);
	import cmptrm_pkg::*;
	logic [7:0] ctrl_rd [2];
	logic [7:0] trim_rd [2];
	logic [1:0] change;
	logic [1:0] pwr, hyst, refp;
	logic [4:0] code [2];
	logic [1:0] stat;
	logic [1:0] mask;
	wire [1:0] next_stat;
	wire [7:0] rsel;
	wire [1:0] next_mask;
	wire [1:0] ctrl_we;
	wire [1:0] trim_we;
	wire wr_stat;
	wire wr_mask;
	wire [1:0] new_flag;
	// ********************
	// Channels
	// ********************
	for (genvar i = 0; i < 2; i++) begin : g_ch
		// Even addresses 0 and 2 hold control, odd ones 1 and 3 trim
		assign ctrl_we[i] = WR_IN && ADDR_IN == 4'(2 * i);
		assign trim_we[i] = WR_IN && ADDR_IN == 4'(2 * i + 1);
		cmptrm_chan u_ch (
			.clk_in(CLK_IN),
			.rstn_in(RSTN_IN),
			.raw_in(RAW_IN[i]),
			.ctrl_we_in(ctrl_we[i]),
			.trim_we_in(trim_we[i]),
			.wdata_in(WDATA_IN),
			.ctrl_out(ctrl_rd[i]),
			.trim_out(trim_rd[i]),
			.change_out(change[i]),
			.power_on_out(pwr[i]),
			.hyst_on_out(hyst[i]),
			.ref_pos_out(refp[i]),
			.trim_code_out(code[i])
		);
	end
	// Status and mask write decode
	assign wr_stat = WR_IN && ADDR_IN == `CMPTRM_STAT;
	assign wr_mask = WR_IN && ADDR_IN == `CMPTRM_MASK;
	assign next_stat = change | (stat & ~(wr_stat ? WDATA_IN[1:0] : 2'b00));
	// a mask write counts at once, so the level never lags the register
	assign next_mask = wr_mask ? WDATA_IN[1:0] : mask;
	// only a flag that rises is news; one already high swallows the event
	assign new_flag = change & ~stat;
	// Read select, unmapped reads zero
	assign rsel = (ADDR_IN == `CMPTRM_CTRL0) ? ctrl_rd[0] :
		(ADDR_IN == `CMPTRM_TRIM0) ? trim_rd[0] :
		(ADDR_IN == `CMPTRM_CTRL1) ? ctrl_rd[1] :
		(ADDR_IN == `CMPTRM_TRIM1) ? trim_rd[1] :
		(ADDR_IN == `CMPTRM_STAT) ? {6'h00, stat} :
		(ADDR_IN == `CMPTRM_MASK) ? {6'h00, mask} : 8'h00;
	// ********************
	// Status, mask, outputs
	// ********************
	// masked interrupt
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			stat <= 2'b00;
			mask <= 2'b00;
			RDATA_OUT <= 8'h00;
			IRQ_OUT <= 1'b0;
			WAKE_OUT <= 1'b0;
			POWER_OUT <= 2'b00;
			HYST_OUT <= 2'b00;
			REF_POS_OUT <= 2'b00;
			TRIM_OUT <= 10'h000;
		end else begin
			stat <= next_stat;
			mask <= next_mask;
			RDATA_OUT <= RD_IN ? rsel : 8'h00;
			IRQ_OUT <= |(next_stat & next_mask);
			// wake on a fresh flag only
			WAKE_OUT <= SLEEP_IN & |new_flag;
			POWER_OUT <= pwr;
			HYST_OUT <= hyst;
			REF_POS_OUT <= refp;
			TRIM_OUT <= {code[1], code[0]};
		end
	end
	// ********************
	// Assertions
	// ********************
	// change sets flag
	property p_set;
		@(posedge CLK_IN) disable iff (!RSTN_IN) change[0] |=> stat[0];
	endproperty
	a_set: assert property (p_set)
		else $error("flag not set");
	property p_set1;
		@(posedge CLK_IN) disable iff (!RSTN_IN) change[1] |=> stat[1];
	endproperty
	a_set1: assert property (p_set1)
		else $error("flag one not set");
	property p_keep;
		@(posedge CLK_IN) disable iff (!RSTN_IN) (stat[0] && !(wr_stat && WDATA_IN[0])) |=> stat[0];
	endproperty
	a_keep: assert property (p_keep)
		else $error("flag dropped by itself");
	property p_clear;
		@(posedge CLK_IN) disable iff (!RSTN_IN) (wr_stat && WDATA_IN[0] && !change[0]) |=> !stat[0];
	endproperty
	a_clear: assert property (p_clear)
		else $error("flag not cleared");
	property p_irq;
		@(posedge CLK_IN) disable iff (!RSTN_IN) IRQ_OUT == |(stat & mask);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq mismatch");
	property p_wake;
		@(posedge CLK_IN) disable iff (!RSTN_IN) (SLEEP_IN && new_flag != 2'b00) |=> WAKE_OUT;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake");
	property p_no_wake;
		@(posedge CLK_IN) disable iff (!RSTN_IN) (!SLEEP_IN || new_flag == 2'b00) |=> !WAKE_OUT;
	endproperty
	a_no_wake: assert property (p_no_wake)
		else $error("wake without new flag");
	property p_pwr_off;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
			(ctrl_we[0] && !WDATA_IN[`CMPTRM_EN_BIT]) |=> ##1 !POWER_OUT[0];
	endproperty
	a_pwr_off: assert property (p_pwr_off)
		else $error("power not removed");
	property p_hyst_out;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
			(trim_we[0] && WDATA_IN[`CMPTRM_OFM_BIT]) |=> ##1 !HYST_OUT[0];
	endproperty
	a_hyst_out: assert property (p_hyst_out)
		else $error("hysteresis left on");
	property p_ref;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
			trim_we[0] |=> ##1 REF_POS_OUT[0] == $past(WDATA_IN[`CMPTRM_RSP_BIT], 2);
	endproperty
	a_ref: assert property (p_ref)
		else $error("reference pin wrong");
	property p_rd_top;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
			(RD_IN && (ADDR_IN == `CMPTRM_TRIM0 || ADDR_IN == `CMPTRM_TRIM1)) |=> !RDATA_OUT[7];
	endproperty
	a_rd_top: assert property (p_rd_top)
		else $error("trim top bit read high");
	// codes reach the pins; skipped on the edge after reset, whose outputs are still zero
	property p_trim;
		@(posedge CLK_IN) disable iff (!RSTN_IN)
			$past(RSTN_IN) |-> TRIM_OUT == {$past(code[1]), $past(code[0])};
	endproperty
	a_trim: assert property (p_trim)
		else $error("trim not driven");
endmodule

// ---- inc/cmptrm_map.svh ----
// Register map, field positions, reset values and write masks
// Assumes inclusion by the design files by bare name
// What this block does
// - Mode bit: zero normal, one calibration
// - Reference bit: zero negative, one positive
// - Trim register top bit reads zero
// - Result change sets interrupt flag
// - Flag and enable raise interrupt
// - Interrupt follows internal result, not pin
// - Flag newly set in sleep wakes processor
// - Comparator and flags stay active asleep
// - Result sense follows invert select
// - Disabled comparator powered off, result zero
// - Hysteresis on normal, off in calibration
`ifndef CMPTRM_MAP_SVH
`define CMPTRM_MAP_SVH
// ********************
// Register offsets
// ********************
`define CMPTRM_CTRL0 4'h0
`define CMPTRM_TRIM0 4'h1
`define CMPTRM_CTRL1 4'h2
`define CMPTRM_TRIM1 4'h3
`define CMPTRM_STAT 4'h4
`define CMPTRM_MASK 4'h5
// ********************
// Fields and resets
// ********************
`define CMPTRM_EN_BIT 6
`define CMPTRM_POL_BIT 5
`define CMPTRM_RES_BIT 4
`define CMPTRM_OFM_BIT 6
`define CMPTRM_RSP_BIT 5
`define CMPTRM_CTRL_RST 8'h00
`define CMPTRM_TRIM_RST 8'h10
`define CMPTRM_CTRL_WMASK 8'h6C
`define CMPTRM_TRIM_WMASK 8'h7F
`endif

// ---- inc/cmptrm_pkg.sv ----
// Types shared by the comparator trim block
// Assumes nothing beyond a SystemVerilog compiler
package cmptrm_pkg;
	typedef logic [7:0] cmptrm_byte_t;
	typedef logic [3:0] cmptrm_addr_t;
	typedef logic [4:0] cmptrm_trim_t;
endpackage

// ---- verilog/cmptrm_sync.sv ----
// Two flip-flop synchroniser for one raw analog comparator decision
// Assumes the input is asynchronous to CLK_IN
`timescale 1ns/1ps
module cmptrm_sync (
	input wire logic clk_in, // System clock
	input wire logic rstn_in, // Synchronous reset, low
	input wire logic d_in, // Raw level
	output logic q_out // Synchronised level
);
	logic s1;
	// ********************
	// Two stages
	// ********************
	// First stage only feeds the second
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s1 <= 1'b0;
			q_out <= 1'b0;
		end else begin
			s1 <= d_in;
			q_out <= s1;
		end
	end
endmodule

// ---- verilog/cmptrm_chan.sv ----
// One comparator channel: control, trim, result and change event
// Assumes register writes decoded by the top module
`timescale 1ns/1ps
`include "cmptrm_map.svh"
module cmptrm_chan (
	input wire logic clk_in, // System clock
	input wire logic rstn_in, // Synchronous reset, low
	input wire logic raw_in, // Asynchronous analog decision, plus over minus
	input wire logic ctrl_we_in, // Control register write
	input wire logic trim_we_in, // Trim register write
	input wire logic [7:0] wdata_in, // Write data
	output logic [7:0] ctrl_out, // Control register read value
	output logic [7:0] trim_out, // Trim register read value
	output logic change_out, // Result changed this cycle
	output logic power_on_out, // Analog power enable
	output logic hyst_on_out, // Analog hysteresis enable
	output logic ref_pos_out, // Calibration reference positive
	output logic [4:0] trim_code_out // Analog offset trim
);
	logic [7:0] ctrl;
	logic [7:0] trim;
	logic raw_sync;
	logic result;
	wire next_result;
	cmptrm_sync u_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.d_in(raw_in),
		.q_out(raw_sync)
	);
	assign next_result = ctrl[`CMPTRM_EN_BIT] & (raw_sync ^ ctrl[`CMPTRM_POL_BIT]);
	// ********************
	// Registers
	// ********************
	// mode bit storage
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ctrl <= `CMPTRM_CTRL_RST;
			trim <= `CMPTRM_TRIM_RST;
			result <= 1'b0;
		end else begin
			if (ctrl_we_in)
				ctrl <= wdata_in & `CMPTRM_CTRL_WMASK;
			if (trim_we_in)
				trim <= wdata_in & `CMPTRM_TRIM_WMASK;
			result <= next_result;
		end
	end
	assign change_out = result ^ next_result;
	assign ctrl_out = {ctrl[7:5], result, ctrl[3:0]};
	assign trim_out = trim;
	assign power_on_out = ctrl[`CMPTRM_EN_BIT];
	assign hyst_on_out = ~trim[`CMPTRM_OFM_BIT];
	assign ref_pos_out = trim[`CMPTRM_RSP_BIT];
	assign trim_code_out = trim[4:0];
	// ********************
	// Assertions
	// ********************
	// top bit reads zero
	property p_trim_top;
		@(posedge clk_in) disable iff (!rstn_in) trim_out[7] == 1'b0;
	endproperty
	a_trim_top: assert property (p_trim_top)
		else $error("trim top bit set");
	property p_off_zero;
		@(posedge clk_in) disable iff (!rstn_in) !ctrl[`CMPTRM_EN_BIT] |=> !result;
	endproperty
	a_off_zero: assert property (p_off_zero)
		else $error("result not zero when off");
	property p_hyst;
		@(posedge clk_in) disable iff (!rstn_in)
			trim_we_in |=> hyst_on_out == !$past(wdata_in[`CMPTRM_OFM_BIT]);
	endproperty
	a_hyst: assert property (p_hyst)
		else $error("hysteresis wrong");
	property p_mode;
		@(posedge clk_in) disable iff (!rstn_in)
			trim_we_in |=> trim_out[`CMPTRM_OFM_BIT] == $past(wdata_in[`CMPTRM_OFM_BIT]);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode bit not stored");
	property p_ref_sel;
		@(posedge clk_in) disable iff (!rstn_in)
			trim_we_in |=> ref_pos_out == $past(wdata_in[`CMPTRM_RSP_BIT]);
	endproperty
	a_ref_sel: assert property (p_ref_sel)
		else $error("reference select wrong");
	property p_change;
		@(posedge clk_in) disable iff (!rstn_in) change_out |=> result != $past(result);
	endproperty
	a_change: assert property (p_change)
		else $error("change without result toggle");
endmodule

// ---- testbench/cmptrm_ana_model.sv ----
// Behavioural pair of analog comparators with a trimmable offset
// Assumes trim codes and power enables from the trim block
`timescale 1ns/1ps
module cmptrm_ana_model #(parameter int DIFF0 = 3, parameter int DIFF1 = 9) (
	input wire logic clk_in, // System clock
	input wire logic [1:0] power_in, // Power enables
	input wire logic [9:0] trim_in, // Trim codes
	output logic [1:0] raw_out // Decisions
);
	logic churn = 1'b0;
	// Unpowered outputs churn, so a stale level proves nothing
	always @(posedge clk_in) churn <= ~churn;
	// Trim moves the switching point at once; code 16 is neutral
	assign raw_out[0] = power_in[0] ? (int'(trim_in[4:0]) + DIFF0 > 16) : churn;
	assign raw_out[1] = power_in[1] ? (int'(trim_in[9:5]) + DIFF1 > 16) : churn;
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the comparator trim block
// Assumes the analog model drives the raw decisions
`timescale 1ns/1ps
module tb;
	import cmptrm_pkg::*;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, sleep = 0, rd_d = 0, irq, wake, prev;
	cmptrm_addr_t addr = '0;
	cmptrm_byte_t wdata = '0, rdata, r;
	logic [1:0] raw, power, hyst, refp;
	logic [9:0] trim;
	logic [9:0] expq[$];
	int num_errors = 0, checks_done = 0, seed = 32'h8334, up, dn, k, wakes = 0;
	cmptrm_top cmptrm_top_inst (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .SLEEP_IN(sleep), .RAW_IN(raw), .RDATA_OUT(rdata), .IRQ_OUT(irq),
		.WAKE_OUT(wake), .POWER_OUT(power), .HYST_OUT(hyst), .REF_POS_OUT(refp), .TRIM_OUT(trim));
	cmptrm_ana_model cmptrm_ana_model_inst (.clk_in(clk), .power_in(power), .trim_in(trim), .raw_out(raw));
	initial forever #5 clk = ~clk;
	// ********************
	// Tasks
	// ********************
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [9:0] e, input logic [9:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr_reg(input cmptrm_addr_t a, input cmptrm_byte_t d);
		@(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk); wr <= 1'b0;
	endtask
	// Expected read data is queued before the strobe goes out
	task rd_reg(input cmptrm_addr_t a, input cmptrm_byte_t e);
		expq.push_back({2'b00, e});
		@(posedge clk); addr <= a; rd <= 1'b1;
		@(posedge clk); rd <= 1'b0;
	endtask
	function automatic logic res(input int t, input logic pol);
		return ((t + 3) > 16) ^ pol;
	endfunction
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_d <= rd;
		if (wake) wakes <= wakes + 1;
	end
	always @(negedge clk) if (rd_d) chk("rdata", expq.size() ? expq.pop_front() : 10'h3FF, {2'b00, rdata});
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict;
	end
	// ********************
	// Main sequence
	// ********************
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(4'h0, 8'h00);
		rd_reg(4'h1, 8'h10);
		chk("hyst", 10'h3, {8'h00, hyst});
		chk("trim", 10'h210, trim);
		rd_reg(4'hF, 8'h00);
		wr_reg(4'hE, 8'hFF);
		for (k = 0; k < 8; k++) begin
			r = cmptrm_byte_t'($random(seed));
			wr_reg(4'h3, r);
			rd_reg(4'h3, r & 8'h7F);
		end
		wr_reg(4'h1, 8'h40);
		repeat (2) @(posedge clk);
		chk("hyst0", 10'h0, {9'h0, hyst[0]});
		chk("ref0", 10'h0, {9'h0, refp[0]});
		wr_reg(4'h1, 8'h60);
		wr_reg(4'h0, 8'h40);
		repeat (8) @(posedge clk);
		chk("ref0", 10'h1, {9'h0, refp[0]});
		chk("pwr0", 10'h1, {9'h0, power[0]});
		// Upward then downward sweep, stop on the first toggle
		prev = res(0, 1'b0);
		rd_reg(4'h0, {3'b010, prev, 4'h0});
		up = 0;
		do begin
			up++;
			wr_reg(4'h1, {3'b011, up[4:0]});
			repeat (8) @(posedge clk);
			rd_reg(4'h0, {3'b010, res(up, 1'b0), 4'h0});
		end while (res(up, 1'b0) == prev && up < 31);
		dn = 31;
		wr_reg(4'h1, 8'h7F);
		repeat (8) @(posedge clk);
		prev = res(31, 1'b0);
		rd_reg(4'h0, {3'b010, prev, 4'h0});
		do begin
			dn--;
			wr_reg(4'h1, {3'b011, dn[4:0]});
			repeat (8) @(posedge clk);
			rd_reg(4'h0, {3'b010, res(dn, 1'b0), 4'h0});
		end while (res(dn, 1'b0) == prev && dn > 0);
		k = (up + dn) / 2;
		wr_reg(4'h1, {3'b011, k[4:0]});
		repeat (2) @(posedge clk);
		chk("trim0", 10'(k), {5'h00, trim[4:0]});
		// Polarity flip while asleep must flag, interrupt and wake
		wr_reg(4'h1, {3'b000, k[4:0]});
		wr_reg(4'h5, 8'h01);
		repeat (8) @(posedge clk);
		wr_reg(4'h4, 8'h03);
		chk("wake", 10'h0, 10'(wakes));
		sleep <= 1'b1;
		wr_reg(4'h0, 8'h60);
		repeat (8) @(posedge clk);
		chk("irq", 10'h1, {9'h0, irq});
		chk("wake", 10'h1, 10'(wakes));
		rd_reg(4'h0, {3'b011, res(k, 1'b1), 4'h0});
		rd_reg(4'h4, 8'h01);
		wr_reg(4'h4, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq", 10'h0, {9'h0, irq});
		wr_reg(4'h5, 8'h00);
		wr_reg(4'h0, 8'h40);
		repeat (8) @(posedge clk);
		chk("irq", 10'h0, {9'h0, irq});
		rd_reg(4'h4, 8'h01);
		wr_reg(4'h0, 8'h20);
		repeat (8) @(posedge clk);
		rd_reg(4'h0, 8'h20);
		chk("pwr0", 10'h0, {9'h0, power[0]});
		// Flag left high before a change in sleep: the change must not wake
		chk("wake", 10'h2, 10'(wakes));
		wr_reg(4'h0, 8'h60);
		repeat (8) @(posedge clk);
		chk("wake", 10'h2, 10'(wakes));
		rd_reg(4'h4, 8'h01);
		repeat (4) @(posedge clk);
		give_verdict;
	end
endmodule
